// ### src/lcl_config_loader.sv
// Configure command loader: fetch sequencer and decoded settings
`timescale 1ns/10ps
module lcl_config_loader
  import lcl_pkg::*;
#(
  parameter int CFG_BYTES = 14
) (
  input  wire logic         sys_clk,
  input  wire logic         reset_n,
  input  wire logic         clk_en,
  input  wire logic         soft_reset,
  input  wire logic [1:0]   mem_mode,
  input  wire logic         cmd_valid,
  input  wire logic [31:0]  cmd_word,
  output logic              cmd_ready,
  input  wire logic         param_valid,
  input  wire logic [7:0]   param_data,
  output logic              param_ready,
  input  wire logic         engine_abort,
  output logic              stat_valid,
  output logic [15:0]       stat_word,
  input  wire logic         stat_ready,
  output logic              cfg_busy,
  output logic [3:0]        param_byte_count,
  output logic              desc_prefetch_mark,
  output logic [3:0]        fifo_limit,
  output logic [1:0]        rx_monitor,
  output logic              refetch_on_resume,
  output logic              keep_bad_frames,
  output logic [2:0]        addr_size,
  output logic              suppress_src_insert,
  output logic [1:0]        preface_size,
  output logic [1:0]        loop_select,
  output logic [2:0]        linear_precedence,
  output logic [2:0]        exponential_precedence,
  output logic              retry_delay_method,
  output logic [7:0]        frame_spacing,
  output logic [10:0]       slot_time,
  output logic [3:0]        retry_limit,
  output logic              accept_all_frames,
  output logic              reject_broadcast,
  output logic              line_coding_select,
  output logic              send_without_carrier,
  output logic              skip_fcs_append,
  output logic              fcs_16bit,
  output logic              stuffing_framing,
  output logic              pad_frames,
  output logic [2:0]        carrier_filter_len,
  output logic              carrier_source_sel,
  output logic [2:0]        collision_filter_len,
  output logic              collision_source_sel,
  output logic [7:0]        shortest_frame_size,
  output logic              preface_until_carrier,
  output logic              length_field_padding,
  output logic              keep_rx_fcs_in_memory,
  output logic              automatic_resend,
  output logic              collision_by_source_match,
  output logic              accept_all_group_frames,
  output logic              full_duplex,
  output logic              multi_addr,
  output logic              no_backoff
);

  // The byte table and count limits are sized for exactly this range
  if (CFG_BYTES != CFG_BYTES_MAX) begin : g_bad_size
    $error("CFG_BYTES must equal the store size of 14");
  end

  typedef enum logic [1:0] {
    LCL_IDLE,     // Waiting for a configure block
    LCL_MARK,     // Writing busy status
    LCL_FETCH,    // Loading parameter bytes
    LCL_FINISH    // Writing completion status
  } lcl_state_t;

  lcl_state_t  state, next_state;      // Sequencer state
  logic [3:0]  idx, next_idx;          // Next byte to load
  logic [3:0]  total, next_total;      // Clamped byte count
  logic        aborted, next_aborted;  // Abort seen for this block
  logic        legacy, next_legacy;    // Mode latched each cycle
  logic [15:0] next_stat_word;         // Status word to write
  logic [3:0]  raw_cnt;                // Count field of byte 0
  logic        is_config;              // Block carries our code

  lcl_cfg_if #(.N(CFG_BYTES)) cfg ();

  lcl_param_store #(.N(CFG_BYTES)) u_store (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .cfg     (cfg)
  );

  // Only the configure code is taken; other commands go elsewhere
  assign is_config   = cmd_word[CMD_MSB:CMD_LSB] == CMD_CONFIGURE; // see R1
  assign cmd_ready   = clk_en && state == LCL_IDLE && is_config;   // see R1
  // An abort takes precedence over the byte offered alongside it
  assign param_ready = clk_en && state == LCL_FETCH && !engine_abort;
  assign stat_valid  = state == LCL_MARK || state == LCL_FINISH;
  assign cfg_busy    = state != LCL_IDLE;
  assign raw_cnt     = param_data[3:0];

  // Store write port driven straight from the accepted byte
  assign cfg.wr_en        = param_valid && param_ready;
  assign cfg.wr_idx       = idx;
  assign cfg.wr_data      = param_data;
  assign cfg.keep_monitor = idx != 4'h0 && total < CNT_MONITOR; // see R9
  assign cfg.soft_reset   = soft_reset;                          // see R22

  // Sequencer next-state logic
  always_comb begin
    next_state     = state;
    next_idx       = idx;
    next_total     = total;
    next_aborted   = aborted;
    next_stat_word = stat_word;
    next_legacy    = mem_mode == MODE_LEGACY;
    unique case (state)
      LCL_IDLE: begin
        if (cmd_valid && cmd_ready) begin
          next_idx       = 4'h0;
          next_total     = CNT_NEW_MIN;
          next_aborted   = 1'b0;
          // Busy alone; complete stays clear in the same write
          next_stat_word = 16'h0000;
          next_stat_word[ST_B] = 1'b1;                       // see R21
          next_state     = LCL_MARK;
        end
      end
      LCL_MARK: begin
        if (engine_abort) begin
          next_aborted = 1'b1;                               // see R19
          next_state   = LCL_FINISH;
        end else if (stat_ready) begin
          next_state = LCL_FETCH;
        end
      end
      LCL_FETCH: begin
        if (engine_abort) begin
          next_aborted = 1'b1;                               // see R19
          next_state   = LCL_FINISH;
        end else if (param_valid) begin
          if (idx == 4'h0) begin
            // Count includes byte 0; clamp by memory mode
            if (legacy) begin
              if (raw_cnt > CNT_LEGACY_MAX) begin
                next_total = CNT_LEGACY_MAX;                 // see R2
              end else if (raw_cnt < CNT_LEGACY_MIN) begin
                next_total = CNT_LEGACY_MIN;                 // see R2
              end else begin
                next_total = raw_cnt;                        // see R6
              end
            end else begin
              if (raw_cnt > CNT_NEW_MAX) begin
                next_total = CNT_NEW_MAX;                    // see R3
              end else if (raw_cnt < CNT_NEW_MIN) begin
                next_total = CNT_NEW_MIN;
              end else begin
                next_total = raw_cnt;                        // see R6
              end
            end
            // Newer modes may clamp to one byte; such a block finishes after byte 0
            next_idx = 4'h1;
            if (!legacy && raw_cnt <= CNT_NEW_MIN) begin
              next_state = LCL_FINISH;                       // see R6
            end
          end else begin
            next_idx = idx + 4'h1;
            if (idx + 4'h1 == total) begin
              next_state = LCL_FINISH;                       // see R24
            end
          end
        end
      end
      LCL_FINISH: begin
        if (stat_ready) begin
          next_state = LCL_IDLE;
        end
      end
    endcase
    // Completion word: complete set, busy cleared, together
    if (next_state == LCL_FINISH && state != LCL_FINISH) begin
      next_stat_word        = 16'h0000;
      next_stat_word[ST_C]  = 1'b1;                          // see R21
      next_stat_word[ST_OK] = !next_aborted;
      next_stat_word[ST_A]  = next_aborted;                  // see R19
    end
    if (soft_reset) begin
      next_state     = LCL_IDLE;
      next_idx       = 4'h0;
      next_total     = CNT_NEW_MIN;
      next_aborted   = 1'b0;
      next_stat_word = 16'h0000;
    end
  end

  // Sequencer registers; all frozen while clk_en is low
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state     <= LCL_IDLE;
      idx       <= 4'h0;
      total     <= CNT_NEW_MIN;
      aborted   <= 1'b0;
      legacy    <= 1'b1;
      stat_word <= 16'h0000;
    end else if (clk_en) begin
      state     <= next_state;
      idx       <= next_idx;
      total     <= next_total;
      aborted   <= next_aborted;
      legacy    <= next_legacy;
      stat_word <= next_stat_word;
    end
  end

  assign param_byte_count = cfg.bytes[IX_COUNT][3:0];               // see R6
  // Prefetch marking and added serial features exist only in newer modes
  assign desc_prefetch_mark = !legacy &&
                              cfg.bytes[IX_COUNT][B_PREFETCH]; // see R7
  assign fifo_limit        = cfg.bytes[IX_FIFO][3:0];               // see R8
  assign rx_monitor        = cfg.bytes[IX_FIFO][7:6];
  assign refetch_on_resume = cfg.bytes[IX_RXOPT][B_RESUME];         // see R10
  assign keep_bad_frames   = cfg.bytes[IX_RXOPT][B_SAVEBAD];        // see R11
  assign addr_size           = cfg.bytes[IX_ADDR][2:0];             // see R12
  assign suppress_src_insert = cfg.bytes[IX_ADDR][B_BIT3];
  assign preface_size        = cfg.bytes[IX_ADDR][5:4];
  assign loop_select         = cfg.bytes[IX_ADDR][7:6];
  assign linear_precedence      = cfg.bytes[IX_PRIO][2:0];          // see R23
  assign exponential_precedence = cfg.bytes[IX_PRIO][6:4];
  assign retry_delay_method     = cfg.bytes[IX_PRIO][B_BIT7];
  assign frame_spacing = cfg.bytes[IX_SPACE];
  assign slot_time     = {cfg.bytes[IX_SLOTH][2:0], cfg.bytes[IX_SLOTL]};
  assign retry_limit   = cfg.bytes[IX_SLOTH][7:4];
  assign accept_all_frames    = cfg.bytes[IX_LINE][0];              // see R13
  assign reject_broadcast     = cfg.bytes[IX_LINE][1];
  assign line_coding_select   = cfg.bytes[IX_LINE][2];
  assign send_without_carrier = cfg.bytes[IX_LINE][3];
  assign skip_fcs_append      = cfg.bytes[IX_LINE][4];              // see R14
  assign fcs_16bit            = cfg.bytes[IX_LINE][5];
  assign stuffing_framing     = cfg.bytes[IX_LINE][6];
  assign pad_frames           = cfg.bytes[IX_LINE][7];
  assign carrier_filter_len   = cfg.bytes[IX_FILT][2:0];            // see R15
  assign carrier_source_sel   = cfg.bytes[IX_FILT][B_BIT3];
  assign collision_filter_len = cfg.bytes[IX_FILT][6:4];
  assign collision_source_sel = cfg.bytes[IX_FILT][B_BIT7];
  assign shortest_frame_size  = cfg.bytes[IX_MINLEN];               // see R16
  assign preface_until_carrier     = cfg.bytes[IX_EXTRA][0];        // see R17
  assign length_field_padding      = cfg.bytes[IX_EXTRA][1];
  assign keep_rx_fcs_in_memory     = cfg.bytes[IX_EXTRA][2];
  assign automatic_resend          = cfg.bytes[IX_EXTRA][3];        // see R18
  assign collision_by_source_match = cfg.bytes[IX_EXTRA][4];
  assign accept_all_group_frames   = cfg.bytes[IX_EXTRA][5];
  assign full_duplex = cfg.bytes[IX_DUPLEX][B_BIT6] && !legacy;     // see R5
  assign multi_addr  = cfg.bytes[IX_MULTI][B_BIT6] && !legacy;      // see R5
  assign no_backoff  = cfg.bytes[IX_MULTI][B_BIT7] && !legacy;      // see R5

  // Named steps of a block: accepted, and abort seen while fetching
  sequence s_taken;
    cmd_valid && cmd_ready && !soft_reset;
  endsequence

  sequence s_abort_fetch;
    clk_en && state == LCL_FETCH && engine_abort && !soft_reset;
  endsequence

  a_cmd_code: assert property (                             // see R1
    @(posedge sys_clk) disable iff (!reset_n)
    s_taken |-> cmd_word[CMD_MSB:CMD_LSB] == CMD_CONFIGURE)
    else $error("non-configure command taken");

  a_busy_mark: assert property (                            // see R21
    @(posedge sys_clk) disable iff (!reset_n)
    s_taken |=> stat_valid && stat_word[ST_B] && !stat_word[ST_C])
    else $error("busy mark not written after take");

  a_status_together: assert property (                      // see R21
    @(posedge sys_clk) disable iff (!reset_n)
    stat_valid |-> stat_word[ST_C] != stat_word[ST_B])
    else $error("complete and busy inconsistent");

  a_legacy_clamp: assert property (                         // see R2
    @(posedge sys_clk) disable iff (!reset_n)
    (state == LCL_FETCH && legacy && idx != 4'h0)
    |-> total >= CNT_LEGACY_MIN && total <= CNT_LEGACY_MAX)
    else $error("legacy count out of 4..12");

  a_new_clamp: assert property (                            // see R3
    @(posedge sys_clk) disable iff (!reset_n)
    (state == LCL_FETCH && !legacy) |-> total <= CNT_NEW_MAX)
    else $error("count above 14 in newer mode");

  a_load_bound: assert property (                           // see R6
    @(posedge sys_clk) disable iff (!reset_n)
    (state == LCL_FETCH && idx != 4'h0) |-> idx < total)
    else $error("loading beyond byte count");

  a_abort_status: assert property (                         // see R19
    @(posedge sys_clk) disable iff (!reset_n)
    s_abort_fetch |=> state == LCL_FINISH && stat_word[ST_A] &&
                      !stat_word[ST_OK] && stat_word[ST_C])
    else $error("abort not reported");

  a_done_all: assert property (                             // see R24
    @(posedge sys_clk) disable iff (!reset_n)
    (stat_valid && stat_word[ST_C] && !stat_word[ST_A] && idx != 4'h1)
    |-> idx == total)
    else $error("completion before all bytes applied");

  a_legacy_off: assert property (                           // see R5
    @(posedge sys_clk) disable iff (!reset_n)
    legacy |-> !full_duplex && !multi_addr && !no_backoff &&
               !desc_prefetch_mark)
    else $error("added feature active in legacy mode");

endmodule : lcl_config_loader

// ### src/lcl_pkg.sv
// Constants, field layout and defaults of the configure command loader
//
// Functional notes
// R1 - Command code 2h in bits 16-18 configures
// R2 - Legacy mode clamps byte count to 4..12
// R3 - Newer modes load up to 14 bytes
// R4 - Host writes byte 11 all ones in legacy
// R5 - Legacy mode keeps added serial features off
// R6 - Byte 0 low nibble counts bytes loaded
// R7 - Byte 0 bit 7 marks prefetched descriptors
// R8 - Byte 1 low nibble is FIFO limit
// R9 - Monitor bits ignored when count below 12
// R10 - Byte 2 bit 1 enables resume re-fetch
// R11 - Byte 2 bit 7 keeps bad frames
// R12 - Byte 3 holds address, preface, loopback fields
// R13 - Byte 8 low bits: filter, coding, carrier
// R14 - Byte 8 high bits: FCS, stuffing, padding
// R15 - Byte 9 holds carrier and collision filters
// R16 - Byte 10 is shortest frame size
// R17 - Byte 11 low bits: preface, length, FCS
// R18 - Byte 11 high bits: resend, group, monitor; bits 7:6 of byte 11 are unused, rx_monitor is taken from byte 1
// R19 - Abort sets aborted bit, else cleared
// R20 - Host zeroes word bits 19-28 in newer modes
// R21 - Complete and busy written in one word
// R22 - Any reset restores every default
// R23 - Bytes 4-7 hold backoff, spacing, slot, retries
// R24 - Unloaded bytes unchanged; done after all applied
package lcl_pkg;

  // Command word layout
  localparam int          CMD_LSB        = 16;
  localparam int          CMD_MSB        = 18;
  localparam logic [2:0]  CMD_CONFIGURE  = 3'h2;

  // Memory structure modes presented on mem_mode
  localparam logic [1:0]  MODE_LEGACY    = 2'h0;
  localparam logic [1:0]  MODE_SEGMENTED = 2'h1;
  localparam logic [1:0]  MODE_LINEAR    = 2'h2;

  // Byte count limits
  localparam logic [3:0]  CNT_LEGACY_MAX = 4'hC;
  localparam logic [3:0]  CNT_LEGACY_MIN = 4'h4;
  localparam logic [3:0]  CNT_NEW_MAX    = 4'hE;
  localparam logic [3:0]  CNT_NEW_MIN    = 4'h1;
  localparam logic [3:0]  CNT_MONITOR    = 4'hC;
  localparam int          CFG_BYTES_MAX  = 14;

  // Byte indices
  localparam int          IX_COUNT  = 0;
  localparam int          IX_FIFO   = 1;
  localparam int          IX_RXOPT  = 2;
  localparam int          IX_ADDR   = 3;
  localparam int          IX_PRIO   = 4;
  localparam int          IX_SPACE  = 5;
  localparam int          IX_SLOTL  = 6;
  localparam int          IX_SLOTH  = 7;
  localparam int          IX_LINE   = 8;
  localparam int          IX_FILT   = 9;
  localparam int          IX_MINLEN = 10;
  localparam int          IX_EXTRA  = 11;
  localparam int          IX_DUPLEX = 12;
  localparam int          IX_MULTI  = 13;

  // Single bit positions
  localparam int          B_PREFETCH = 7;
  localparam int          B_RESUME   = 1;
  localparam int          B_SAVEBAD  = 7;
  localparam int          B_BIT3     = 3;
  localparam int          B_BIT7     = 7;
  localparam int          B_BIT6     = 6;

  // Status word of the even half of the block
  localparam int          ST_C   = 15;
  localparam int          ST_B   = 14;
  localparam int          ST_OK  = 13;
  localparam int          ST_A   = 12;

  // Reset values of all configuration bytes
  localparam logic [7:0]  DEF_BYTE [CFG_BYTES_MAX] = '{
    8'h0E, 8'hC8, 8'h40, 8'h26, 8'h00, 8'h60, 8'h00,
    8'hF2, 8'h00, 8'h00, 8'h40, 8'hFF, 8'h00, 8'h3F};

endpackage : lcl_pkg

// ### src/lcl_cfg_if.sv
// Interface between the loader sequencer and the parameter store
`timescale 1ns/10ps
interface lcl_cfg_if #(parameter int N = 14);
  logic        wr_en;        // Write one parameter byte
  logic [3:0]  wr_idx;       // Byte index
  logic [7:0]  wr_data;      // Byte value
  logic        keep_monitor; // Protect monitor bits of byte 1
  logic        soft_reset;   // Restore defaults
  logic [7:0]  bytes [N];    // Current configuration

  modport loader (output wr_en, wr_idx, wr_data, keep_monitor,
                  soft_reset, input bytes);
  modport store  (input wr_en, wr_idx, wr_data, keep_monitor,
                  soft_reset, output bytes);
endinterface : lcl_cfg_if

// ### src/lcl_param_store.sv
// Configuration byte store with reset defaults
`timescale 1ns/10ps
module lcl_param_store
  import lcl_pkg::*;
#(
  parameter int N = 14
) (
  input  wire logic  sys_clk,
  input  wire logic  reset_n,
  input  wire logic  clk_en,
  lcl_cfg_if.store   cfg
);

  logic [7:0] mem      [N];  // Stored bytes
  logic [7:0] next_mem [N];  // Next values

  // Per-entry next value; untouched bytes hold their value
  for (genvar i = 0; i < N; i++) begin : g_entry
    always_comb begin
      next_mem[i] = mem[i];                                  // see R24
      if (cfg.soft_reset) begin
        next_mem[i] = DEF_BYTE[i];                           // see R22
      end else if (cfg.wr_en && cfg.wr_idx == 4'(i)) begin
        next_mem[i] = cfg.wr_data;
        // Short loads must not disturb the monitor setting
        if (i == IX_FIFO && cfg.keep_monitor) begin
          next_mem[i][7:6] = mem[i][7:6];                    // see R9
        end
      end
    end

    // Registers only; reset takes the defaults
    always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
        mem[i] <= DEF_BYTE[i];                               // see R22
      end else if (clk_en) begin
        mem[i] <= next_mem[i];
      end
    end

    assign cfg.bytes[i] = mem[i];
  end

  // Monitor bits of byte 1 survive a short load
  a_monitor_kept: assert property (                          // see R9
    @(posedge sys_clk) disable iff (!reset_n)
    (clk_en && cfg.wr_en && cfg.wr_idx == 4'(IX_FIFO) &&
     cfg.keep_monitor && !cfg.soft_reset)
    |=> $stable(mem[IX_FIFO][7:6]))
    else $error("monitor bits changed on short load");

endmodule : lcl_param_store

// ### tb/lcl_host_model.sv
// Host side model: offers configure blocks and accepts status writes
`timescale 1ns/10ps
module lcl_host_model
  import lcl_pkg::*;
(
  input  wire logic        sys_clk,
  output logic             cmd_valid,
  output logic [31:0]      cmd_word,
  input  wire logic        cmd_ready,
  output logic             param_valid,
  output logic [7:0]       param_data,
  input  wire logic        param_ready,
  input  wire logic        stat_valid,
  input  wire logic [15:0] stat_word,
  output logic             stat_ready
);
  // Idle host: nothing offered
  initial begin
    cmd_valid   = 1'h0;
    cmd_word    = 32'h0000_0000;
    param_valid = 1'h0;
    param_data  = 8'h00;
    stat_ready  = 1'h0;
  end

  // Present a command word; reserved bits stay zero
  task automatic offer(input logic [2:0] code, output logic rdy);
    @(negedge sys_clk);
    cmd_word                  = 32'h0000_0000;
    cmd_word[CMD_MSB:CMD_LSB] = code;
    cmd_valid                 = 1'h1;
    #1;
    rdy = cmd_ready;
  endtask : offer

  // Withdraw a command that was never taken
  task automatic drop();
    @(negedge sys_clk);
    cmd_valid = 1'h0;
    cmd_word  = ~cmd_word;
  endtask : drop

  // Accept one status write; gap models a slow memory
  task automatic take_stat(input int gap, output logic [15:0] st);
    int k;
    k = 0;
    @(negedge sys_clk);
    while (stat_valid !== 1'h1 && k < 100) begin
      @(negedge sys_clk);
      k++;
    end
    repeat (gap) @(negedge sys_clk);
    st         = stat_word;
    stat_ready = 1'h1;
    @(negedge sys_clk);
    stat_ready = 1'h0;
  endtask : take_stat

  // Whole configure block; bytes offered in order, byte 0 first
  task automatic cfg_run(input logic [7:0] b [14], input int gap,
                         output int n, output logic [15:0] mark,
                         output logic [15:0] done);
    logic r;
    int   k;
    offer(CMD_CONFIGURE, r);
    k = 0;
    while (r !== 1'h1 && k < 100) begin
      @(negedge sys_clk);
      #1;
      r = cmd_ready;
      k++;
    end
    @(negedge sys_clk);
    cmd_valid = 1'h0;
    cmd_word  = ~cmd_word;
    take_stat(gap, mark);
    n = 0;
    // Offer all 14; the device stops taking at its own count
    for (int i = 0; i < 14; i++) begin
      repeat (gap) @(negedge sys_clk);
      param_valid = 1'h1;
      param_data  = b[i];
      #1;
      k = 0;
      while (param_ready !== 1'h1 && stat_valid !== 1'h1 && k < 100) begin
        @(negedge sys_clk);
        #1;
        k++;
      end
      if (param_ready !== 1'h1) break;
      @(negedge sys_clk);
      n++;
      // Released data line shows the inverse, never a stale byte
      if (gap > 0) begin
        param_valid = 1'h0;
        param_data  = ~b[i];
      end
    end
    param_valid = 1'h0;
    param_data  = ~param_data;
    take_stat(gap, done);
  endtask : cfg_run
endmodule : lcl_host_model

// ### tb/lcl_config_loader_tb_top.sv
// Self-checking bench of the configure command loader
`timescale 1ns/10ps
module lcl_config_loader_tb_top;
  import lcl_pkg::*;
  logic sys_clk, reset_n, clk_en, soft_reset, engine_abort, cfg_busy;
  logic cmd_valid, cmd_ready, param_valid, param_ready, stat_valid, stat_ready;
  logic [1:0]  mem_mode, rx_monitor, preface_size, loop_select;
  logic [31:0] cmd_word;
  logic [15:0] stat_word;
  logic [10:0] slot_time;
  logic [7:0]  param_data, frame_spacing, shortest_frame_size;
  logic [3:0]  param_byte_count, fifo_limit, retry_limit;
  logic [2:0]  addr_size, linear_precedence, exponential_precedence;
  logic [2:0]  carrier_filter_len, collision_filter_len;
  logic desc_prefetch_mark, refetch_on_resume, keep_bad_frames;
  logic suppress_src_insert, retry_delay_method, accept_all_frames;
  logic reject_broadcast, line_coding_select, send_without_carrier;
  logic skip_fcs_append, fcs_16bit, stuffing_framing, pad_frames;
  logic carrier_source_sel, collision_source_sel, preface_until_carrier;
  logic length_field_padding, keep_rx_fcs_in_memory, automatic_resend;
  logic collision_by_source_match, accept_all_group_frames;
  logic full_duplex, multi_addr, no_backoff;
  logic [7:0]  got [14];   // Settings regrouped into parameter bytes
  logic [7:0]  exp [14];   // Expected parameter bytes
  logic        r;
  int          bad_count, checked;
  // Bits that the ports expose, per byte
  localparam logic [7:0] MSK [14] = '{8'h8F, 8'hCF, 8'h82, 8'hFF, 8'hF7,
    8'hFF, 8'hFF, 8'hF7, 8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'h40, 8'hC0};

  lcl_config_loader #(.CFG_BYTES(14)) uut (.*);
  lcl_host_model host (.*);

  // Rebuild bytes from decoded outputs so one loop checks them all
  assign got[0]  = {desc_prefetch_mark, 3'h0, param_byte_count};
  assign got[1]  = {rx_monitor, 2'h0, fifo_limit};
  assign got[2]  = {keep_bad_frames, 5'h00, refetch_on_resume, 1'h0};
  assign got[3]  = {loop_select, preface_size, suppress_src_insert, addr_size};
  assign got[4]  = {retry_delay_method, exponential_precedence, 1'h0,
                    linear_precedence};
  assign got[5]  = frame_spacing;
  assign got[6]  = slot_time[7:0];
  assign got[7]  = {retry_limit, 1'h0, slot_time[10:8]};
  assign got[8]  = {pad_frames, stuffing_framing, fcs_16bit, skip_fcs_append,
                    send_without_carrier, line_coding_select,
                    reject_broadcast, accept_all_frames};
  assign got[9]  = {collision_source_sel, collision_filter_len,
                    carrier_source_sel, carrier_filter_len};
  assign got[10] = shortest_frame_size;
  assign got[11] = {2'h0, accept_all_group_frames, collision_by_source_match,
                    automatic_resend, keep_rx_fcs_in_memory,
                    length_field_padding, preface_until_carrier};
  assign got[12] = {1'h0, full_duplex, 6'h00};
  assign got[13] = {no_backoff, multi_addr, 6'h00};

  // 200 MHz clock
  always #2.5 sys_clk = ~sys_clk;

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp

  // Legacy mode hides the prefetch mark and the two extra bytes
  task automatic check_cfg();
    logic [7:0] g;
    for (int i = 0; i < 14; i++) begin
      g = MSK[i];
      if (mem_mode == MODE_LEGACY && i == 0) g = 8'h0F;
      if (mem_mode == MODE_LEGACY && i >= 12) g = 8'h00;
      cmp(got[i], exp[i] & g);
    end
  endtask : check_cfg

  // One configure block, optional abort ab negedges after start
  task automatic run(input string nm, input logic [7:0] b [14],
                     input int gap, input int ab);
    int          n, c;
    logic [15:0] mk, dn;
    c = b[0][3:0];
    if (mem_mode == MODE_LEGACY) c = c > 12 ? 12 : (c < 4 ? 4 : c);
    else c = c > 14 ? 14 : (c < 1 ? 1 : c);
    fork
      host.cfg_run(b, gap, n, mk, dn);
      if (ab > 0) begin
        repeat (ab) @(negedge sys_clk);
        engine_abort = 1'h1;
        @(negedge sys_clk);
        engine_abort = 1'h0;
      end
    join
    cmp(mk, 16'h4000);
    cmp(dn, ab > 0 ? 16'h9000 : 16'hA000);
    if (ab == 0) cmp(n, c);
    for (int i = 0; i < n; i++) begin
      exp[i] = (i == 1 && c < 12) ? {exp[1][7:6], b[1][5:0]} : b[i];
    end
    @(negedge sys_clk);
    check_cfg();
    $display("test %0s done", nm);
  endtask : run

  task automatic results();
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results

  // Watchdog: all tests need well under 40000 cycles
  initial begin
    #200_000;
    bad_count++;
    results();
  end

  // Test sequence
  initial begin
    sys_clk = 1'h0; reset_n = 1'h0; clk_en = 1'h1; soft_reset = 1'h0;
    engine_abort = 1'h0; mem_mode = MODE_LEGACY; bad_count = 0; checked = 0;
    exp = DEF_BYTE;
    repeat (8) @(negedge sys_clk);
    reset_n = 1'h1;
    @(negedge sys_clk);
    check_cfg();
    $display("test reset done");
    for (int c = 0; c < 8; c++) begin
      if (c != 2) begin
        host.offer(c[2:0], r);
        cmp(r, 1'h0);
        host.drop();
      end
    end
    cmp(cfg_busy, 1'h0);
    $display("test codes done");
    mem_mode = MODE_LINEAR;
    repeat (2) @(negedge sys_clk);
    run("linear_full", '{8'h8E, 8'h37, 8'h82, 8'hD9, 8'hF7, 8'h9C, 8'hFF,
        8'h0D, 8'hFF, 8'hFF, 8'hBF, 8'h00, 8'h40, 8'hC0}, 0, 0);
    mem_mode = MODE_SEGMENTED;
    run("short_slow", '{8'h03, 8'hC1, 8'h00, 8'hAA, 8'hAA, 8'hAA, 8'hAA,
        8'hAA, 8'hAA, 8'hAA, 8'hAA, 8'hAA, 8'hAA, 8'hAA}, 2, 0);
    mem_mode = MODE_LINEAR;
    run("count_zero", '{8'h80, 8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'h55,
        8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'h55}, 0, 0);
    run("abort", '{8'h0E, 8'hC2, 8'h40, 8'h11, 8'h22, 8'h33, 8'h44,
        8'h55, 8'h66, 8'h77, 8'h88, 8'hFF, 8'h00, 8'h3F}, 0, 7);
    mem_mode = MODE_LEGACY;
    run("legacy_clamp_hi", '{8'h8F, 8'h0A, 8'h82, 8'h13, 8'h71, 8'h48,
        8'h21, 8'h63, 8'h5A, 8'hA5, 8'h20, 8'hFF, 8'hFF, 8'hFF}, 1, 0);
    run("legacy_clamp_lo", '{8'h02, 8'h03, 8'h00, 8'h26, 8'h99, 8'h99,
        8'h99, 8'h99, 8'h99, 8'h99, 8'h99, 8'h99, 8'h99, 8'h99}, 0, 0);
    soft_reset = 1'h1;
    @(negedge sys_clk);
    soft_reset = 1'h0;
    exp = DEF_BYTE;
    @(negedge sys_clk);
    check_cfg();
    cmp(cfg_busy, 1'h0);
    $display("test soft_reset done");
    results();
  end
endmodule : lcl_config_loader_tb_top
